// File: rtl/obc_pkg.sv
package obc_pkg;
  // register offsets on the analog page
  localparam logic [6:0] RSVD_A_OFF = 7'h2b;
  localparam logic [6:0] HP_DRV_CTRL_OFF = 7'h2c;
  localparam logic [6:0] RSVD_B_OFF = 7'h2d;
  localparam logic [6:0] BIAS_PD_OFF = 7'h2e;
  localparam logic [6:0] RSVD_C_OFF = 7'h2f;
  localparam logic [6:0] IN_CM_OFF = 7'h32;
  localparam logic [6:0] RSVD_D_OFF = 7'h33;
  // headphone_driver_control fields
  localparam int DBNC_MSB = 7;
  localparam int DBNC_LSB = 5;
  localparam int DRIVE_MSB = 4;
  localparam int DRIVE_LSB = 3;
  localparam int AUX_LINEOUT_BIT = 2;
  // bias_and_power_down fields
  localparam int SOFT_PD_BIT = 7;
  localparam int BIAS_OVR_BIT = 3;
  localparam int BIAS_LVL_MSB = 1;
  localparam int BIAS_LVL_LSB = 0;
  // input_common_mode_settings fields
  localparam int ANALOG_INPUT_ONE_CM_BIT = 7;
  localparam int ANALOG_INPUT_TWO_CM_BIT = 6;
  // reset values, reserved drive code and bias-off code
  localparam logic [2:0] DBNC_RST = 3'h0;
  localparam logic [1:0] DRIVE_RST = 2'h0;
  localparam logic [1:0] DRIVE_RSVD_CODE = 2'h2;
  localparam logic [1:0] BIAS_LVL_RST = 2'h0;
  localparam logic [1:0] BIAS_LVL_OFF = 2'h0;
  // timing
  localparam int CLK_HZ = 10_000_000;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYCLES = (SETTLE_US * (CLK_HZ / 1_000_000));
  localparam int CNT_W = 10;
  localparam int OSC_PER_STEP = 8;
  localparam int DBNC_DIV = 8;
endpackage : obc_pkg

// File: rtl/obc_debounce_gen.sv
`timescale 1ns/1ps
module obc_debounce_gen (
  input wire logic clock, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic [2:0] dbnc_code, // debounce interval code
  input wire logic src_mclk, // 1: divided master clock, 0: internal oscillator
  input wire logic mhz_tick, // 1 MHz enable pulse from the master clock divider
  input wire logic osc_tick, // one pulse per internal oscillator period
  output logic dbnc_tick_q // debounce sampling enable pulse
);
  // ==========================================================
  // base step: one microsecond on the master clock path, eight
  // oscillator periods on the oscillator path (so 8.2 MHz gives 0.975 us)
  logic [2:0] pre_q, pre_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] code_q, code_d;
  logic tick_d;
  logic base_tick;
  // one bit wider than the counter so that 64 steps (code 111) does not wrap to zero
  logic [6:0] period;

  // sampling period is interval / 8, i.e. 2**(code-1) base steps
  always_comb begin
    period = 7'h01 << (dbnc_code - 3'h1); // R01 R03
    base_tick = 1'b0;
    pre_d = pre_q;
    if (src_mclk) begin
      base_tick = mhz_tick; // R15
      pre_d = 3'h0;
    end else if (osc_tick) begin
      // step scales with the real oscillator rate, not a fixed time
      pre_d = pre_q + 3'h1; // R02
      base_tick = (pre_q == 3'(obc_pkg::OSC_PER_STEP - 1));
    end
    code_d = dbnc_code;
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (dbnc_code == 3'h0 || code_q != dbnc_code) begin
      // zero interval: no sampling clock; a new code restarts the count
      cnt_d = 6'h00; // R01
    end else if (base_tick) begin
      if ({1'b0, cnt_q} == period - 7'h01) begin
        cnt_d = 6'h00;
        tick_d = 1'b1; // R03
      end else begin
        cnt_d = cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 3'h0;
      cnt_q <= 6'h00;
      code_q <= 3'h0;
      dbnc_tick_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      dbnc_tick_q <= tick_d;
    end
  end
endmodule : obc_debounce_gen

// File: rtl/obc_regs.sv
// Notes on behaviour
// [R01] three-bit code picks debounce 0, then 8 to 512 us doubling on 1 MHz
// [R02] oscillator source scales intervals with real oscillator rate; code 001 near 7.8 us
// [R03] debounce sampling clock period is selected interval divided by eight
// [R04] two-bit drive field: 00 default, 01 more current, 11 most; 10 reserved
// [R05] one bit: aux driver is headphone driver when clear, line-out when set
// [R06] top bias register bit set enables whole-device software power-down
// [R07] without headset under detection bias stays off unless override bit set
// [R08] bias level field: off, two volts, two and a half volts, analog supply
// [R09] first analog input tied to common mode when its bit set, else floating
// [R10] second analog input tied to common mode when its bit set, else floating
// [R11] software writes zeros into reserved fields of bias and common-mode registers
// [R12] host never writes fully reserved registers with undefined contents
// [R13] host writes back only reset contents into preserve-value reserved ranges
// [R14] delay-timer page defaults readable only 100 us after any reset
// [R15] fixed debounce steps hold for master clock divided down to 1 MHz
// [R16] registers read back last write and load reset values on any reset; a drive code 10 write leaves the old drive field
`timescale 1ns/1ps
module obc_regs (
  input wire logic clock, // system clock, 10 MHz
  input wire logic resetn, // hardware reset, async, active low
  input wire logic soft_reset, // software reset pulse
  input wire logic [6:0] reg_addr, // register offset within the page
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  input wire logic src_mclk, // debounce source: 1 master clock path, 0 oscillator
  input wire logic mhz_tick, // 1 MHz enable pulse from the master clock divider
  input wire logic osc_tick, // internal oscillator period pulse
  input wire logic headset_detect_en, // headset detection enabled
  input wire logic headset_present_pin, // headset inserted, asynchronous pin
  output logic [7:0] reg_rdata_q, // read data
  output logic reg_rvalid_q, // read data valid, one cycle
  output logic dbnc_tick_q, // debounce sampling enable
  output logic [1:0] dac_drive_mode_q, // converter drive current mode
  output logic aux_output_driver_lineout_q, // aux_output_driver as line-out
  output logic soft_power_down_q, // device software power-down
  output logic [1:0] microphone_bias_output_level_q, // bias level code
  output logic microphone_bias_output_en_q, // bias actually powered
  output logic analog_input_one_cm_q, // tie first input to common_mode_level
  output logic analog_input_two_cm_q, // tie second input to common_mode_level
  output logic timer_defaults_valid_q // delay-timer page defaults valid
);
  // ==========================================================
  // types and helpers
  typedef enum logic {SETTLING, READY} obc_settle_t;

  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction : hit

  // ==========================================================
  // pin synchroniser
  logic [1:0] sync_q;
  logic hs_present;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          sync_q[gi] <= 1'b0;
        end else begin
          sync_q[gi] <= (gi == 0) ? headset_present_pin : sync_q[0];
        end
      end
    end
  endgenerate
  assign hs_present = sync_q[1];

  // ==========================================================
  // register storage; reserved fields are not stored and read as zero
  logic [2:0] dbnc_q, dbnc_d;
  logic [1:0] drive_q, drive_d;
  logic lineout_q, lineout_d;
  logic pd_q, pd_d;
  logic ovr_q, ovr_d;
  logic [1:0] lvl_q, lvl_d;
  logic cm1_q, cm1_d;
  logic cm2_q, cm2_d;
  logic [7:0] rdata_d;
  logic rvalid_d;
  logic bias_en_d;

  always_comb begin
    dbnc_d = dbnc_q;
    drive_d = drive_q;
    lineout_d = lineout_q;
    pd_d = pd_q;
    ovr_d = ovr_q;
    lvl_d = lvl_q;
    cm1_d = cm1_q;
    cm2_d = cm2_q;
    if (soft_reset) begin
      dbnc_d = obc_pkg::DBNC_RST; // R16
      drive_d = obc_pkg::DRIVE_RST;
      lineout_d = 1'b0;
      pd_d = 1'b0;
      ovr_d = 1'b0;
      lvl_d = obc_pkg::BIAS_LVL_RST;
      cm1_d = 1'b0;
      cm2_d = 1'b0;
    end else if (reg_wr) begin
      // writes to reserved offsets are dropped; nothing behind them
      if (hit(reg_addr, obc_pkg::HP_DRV_CTRL_OFF)) begin
        dbnc_d = reg_wdata[obc_pkg::DBNC_MSB:obc_pkg::DBNC_LSB]; // R01
        // the reserved code is refused so the converter drive never sees it
        if (reg_wdata[obc_pkg::DRIVE_MSB:obc_pkg::DRIVE_LSB] != obc_pkg::DRIVE_RSVD_CODE) begin
          drive_d = reg_wdata[obc_pkg::DRIVE_MSB:obc_pkg::DRIVE_LSB]; // R04
        end
        lineout_d = reg_wdata[obc_pkg::AUX_LINEOUT_BIT]; // R05
      end
      if (hit(reg_addr, obc_pkg::BIAS_PD_OFF)) begin
        pd_d = reg_wdata[obc_pkg::SOFT_PD_BIT]; // R06
        ovr_d = reg_wdata[obc_pkg::BIAS_OVR_BIT]; // R07
        lvl_d = reg_wdata[obc_pkg::BIAS_LVL_MSB:obc_pkg::BIAS_LVL_LSB]; // R08
      end
      if (hit(reg_addr, obc_pkg::IN_CM_OFF)) begin
        cm1_d = reg_wdata[obc_pkg::ANALOG_INPUT_ONE_CM_BIT]; // R09
        cm2_d = reg_wdata[obc_pkg::ANALOG_INPUT_TWO_CM_BIT]; // R10
      end
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = reg_rd;
    if (reg_rd) begin
      if (hit(reg_addr, obc_pkg::HP_DRV_CTRL_OFF)) begin
        rdata_d[obc_pkg::DBNC_MSB:obc_pkg::DBNC_LSB] = dbnc_q; // R16
        rdata_d[obc_pkg::DRIVE_MSB:obc_pkg::DRIVE_LSB] = drive_q;
        rdata_d[obc_pkg::AUX_LINEOUT_BIT] = lineout_q;
      end
      if (hit(reg_addr, obc_pkg::BIAS_PD_OFF)) begin
        rdata_d[obc_pkg::SOFT_PD_BIT] = pd_q; // R16
        rdata_d[obc_pkg::BIAS_OVR_BIT] = ovr_q;
        rdata_d[obc_pkg::BIAS_LVL_MSB:obc_pkg::BIAS_LVL_LSB] = lvl_q;
      end
      if (hit(reg_addr, obc_pkg::IN_CM_OFF)) begin
        rdata_d[obc_pkg::ANALOG_INPUT_ONE_CM_BIT] = cm1_q; // R16
        rdata_d[obc_pkg::ANALOG_INPUT_TWO_CM_BIT] = cm2_q;
      end
    end
    // bias gated off while the level code is off, or while detection says no headset and the override bit is clear
    bias_en_d = (lvl_q != obc_pkg::BIAS_LVL_OFF)
                && (ovr_q || !headset_detect_en || hs_present); // R07 R08
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dbnc_q <= obc_pkg::DBNC_RST;
      drive_q <= obc_pkg::DRIVE_RST;
      lineout_q <= 1'b0;
      pd_q <= 1'b0;
      ovr_q <= 1'b0;
      lvl_q <= obc_pkg::BIAS_LVL_RST;
      cm1_q <= 1'b0;
      cm2_q <= 1'b0;
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
      microphone_bias_output_en_q <= 1'b0;
    end else begin
      dbnc_q <= dbnc_d;
      drive_q <= drive_d;
      lineout_q <= lineout_d;
      pd_q <= pd_d;
      ovr_q <= ovr_d;
      lvl_q <= lvl_d;
      cm1_q <= cm1_d;
      cm2_q <= cm2_d;
      reg_rdata_q <= rdata_d;
      reg_rvalid_q <= rvalid_d;
      microphone_bias_output_en_q <= bias_en_d;
    end
  end

  // field outputs are the register flops themselves
  assign dac_drive_mode_q = drive_q;
  assign aux_output_driver_lineout_q = lineout_q;
  assign soft_power_down_q = pd_q;
  assign microphone_bias_output_level_q = lvl_q;
  assign analog_input_one_cm_q = cm1_q;
  assign analog_input_two_cm_q = cm2_q;

  // ==========================================================
  // settling timer after hardware or software reset
  obc_settle_t st_q, st_d;
  logic [obc_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic valid_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    valid_d = 1'b0;
    case (st_q)
      SETTLING: begin
        if (cnt_q == obc_pkg::CNT_W'(obc_pkg::SETTLE_CYCLES - 1)) begin
          st_d = READY; // R14
          valid_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      READY: begin
        valid_d = 1'b1;
      end
      default: begin
        st_d = SETTLING;
      end
    endcase
    if (soft_reset) begin
      st_d = SETTLING; // R14
      cnt_d = '0;
      valid_d = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= SETTLING;
      cnt_q <= '0;
      timer_defaults_valid_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      timer_defaults_valid_q <= valid_d;
    end
  end

  // ==========================================================
  // debounce sampling clock
  obc_debounce_gen u_dbnc (
    .clock(clock),
    .resetn(resetn),
    .dbnc_code(dbnc_q),
    .src_mclk(src_mclk),
    .mhz_tick(mhz_tick),
    .osc_tick(osc_tick),
    .dbnc_tick_q(dbnc_tick_q)
  );
endmodule : obc_regs

// File: verif/obc_regs_assertions.sv
`timescale 1ns/1ps
// ==========
// register slice checker
module obc_regs_assertions (
  input wire logic clock, // clock
  input wire logic resetn, // reset, active low
  input wire logic soft_reset, // software reset
  input wire logic [6:0] reg_addr, // offset
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic mhz_tick, // 1 MHz step
  input wire logic osc_tick, // oscillator step
  input wire logic [7:0] reg_rdata_q, // read data
  input wire logic reg_rvalid_q, // read valid
  input wire logic dbnc_tick_q, // debounce tick
  input wire logic [1:0] dac_drive_mode_q, // drive mode
  input wire logic aux_output_driver_lineout_q, // line-out
  input wire logic soft_power_down_q, // power-down
  input wire logic [1:0] microphone_bias_output_level_q, // bias level
  input wire logic microphone_bias_output_en_q, // bias on
  input wire logic analog_input_one_cm_q, // input one tie
  input wire logic analog_input_two_cm_q, // input two tie
  input wire logic timer_defaults_valid_q // defaults valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic wr_ok;
  assign wr_ok = reg_wr && !soft_reset;
  rd_answer_a: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read not answered");
  rdata_idle_a: assert property (!reg_rvalid_q |-> reg_rdata_q == 8'h00)
    else $error("read data not zero while idle");
  bias_read_a: assert property (reg_rd && !wr_ok && !soft_reset &&
    reg_addr == obc_pkg::BIAS_PD_OFF |=> reg_rdata_q[7] == soft_power_down_q &&
    reg_rdata_q[6:4] == 3'h0 && reg_rdata_q[2] == 1'b0 &&
    reg_rdata_q[1:0] == microphone_bias_output_level_q) else $error("bias readback");
  pd_write_a: assert property (wr_ok && reg_addr == obc_pkg::BIAS_PD_OFF |=>
    soft_power_down_q == $past(reg_wdata[7]) &&
    microphone_bias_output_level_q == $past(reg_wdata[1:0])) else $error("bias write");
  drive_rsvd_a: assert property (wr_ok && reg_addr == obc_pkg::HP_DRV_CTRL_OFF &&
    reg_wdata[4:3] == 2'h2 |=> $stable(dac_drive_mode_q)) else $error("reserved drive");
  lineout_a: assert property (wr_ok && reg_addr == obc_pkg::HP_DRV_CTRL_OFF |=>
    aux_output_driver_lineout_q == $past(reg_wdata[2])) else $error("line-out bit");
  cm_write_a: assert property (wr_ok && reg_addr == obc_pkg::IN_CM_OFF |=>
    {analog_input_one_cm_q, analog_input_two_cm_q} == $past(reg_wdata[7:6]))
    else $error("common-mode bits");
  bias_off_a: assert property (microphone_bias_output_level_q == 2'h0 |=>
    !microphone_bias_output_en_q) else $error("bias on at level zero");
  soft_rst_a: assert property (soft_reset |=> !timer_defaults_valid_q &&
    dac_drive_mode_q == 2'h0 && !soft_power_down_q && !analog_input_one_cm_q)
    else $error("soft reset");
  dbnc_src_a: assert property (dbnc_tick_q |-> $past(mhz_tick || osc_tick))
    else $error("debounce tick without step");
endmodule : obc_regs_assertions

bind obc_regs obc_regs_assertions u_chk (.clock(clock), .resetn(resetn),
  .soft_reset(soft_reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .mhz_tick(mhz_tick), .osc_tick(osc_tick),
  .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .dbnc_tick_q(dbnc_tick_q),
  .dac_drive_mode_q(dac_drive_mode_q),
  .aux_output_driver_lineout_q(aux_output_driver_lineout_q),
  .soft_power_down_q(soft_power_down_q),
  .microphone_bias_output_level_q(microphone_bias_output_level_q),
  .microphone_bias_output_en_q(microphone_bias_output_en_q),
  .analog_input_one_cm_q(analog_input_one_cm_q),
  .analog_input_two_cm_q(analog_input_two_cm_q),
  .timer_defaults_valid_q(timer_defaults_valid_q));

// File: verif/obc_host.sv
`timescale 1ns/1ps
// ==========
// control bus host
module obc_host (
  input wire logic clock, // clock
  input wire logic [7:0] reg_rdata_q, // read data
  input wire logic reg_rvalid_q, // read valid
  output logic [6:0] reg_addr, // offset
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_wdata // write data
);
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == 7'h2c) ? 8'hfc : (a == 7'h2e) ? 8'h8b : (a == 7'h32) ? 8'hc0 : 8'h00;
    if (m != 8'h00) begin
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d & m;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      reg_wdata = ~reg_wdata;
    end
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    d = reg_rdata_q;
    v = reg_rvalid_q;
  endtask : rd
endmodule : obc_host

// File: verif/obc_regs_bench.sv
`timescale 1ns/1ps
module obc_regs_bench;
  logic clock, resetn, soft_reset, reg_wr, reg_rd, src_mclk, mhz_tick, osc_tick;
  logic headset_detect_en, headset_present_pin, reg_rvalid_q, dbnc_tick_q, aux, pd;
  logic bias_en, cm1, cm2, valid, v;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_q, d;
  logic [1:0] drive, lvl;
  logic [7:0] mdl [3] = '{8'h00, 8'h00, 8'h00};
  logic [6:0] offs [3] = '{7'h2c, 7'h2e, 7'h32};
  logic [6:0] rsv [5] = '{7'h2b, 7'h2d, 7'h2f, 7'h33, 7'h7f};
  int error_cnt = 0, n_tests = 0, ncyc = 0, ph = 0, k;
  obc_host host (.clock(clock), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  obc_regs u_obc_regs (.clock(clock), .resetn(resetn), .soft_reset(soft_reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .src_mclk(src_mclk), .mhz_tick(mhz_tick), .osc_tick(osc_tick),
    .headset_detect_en(headset_detect_en), .headset_present_pin(headset_present_pin),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q), .dbnc_tick_q(dbnc_tick_q),
    .dac_drive_mode_q(drive), .aux_output_driver_lineout_q(aux), .soft_power_down_q(pd),
    .microphone_bias_output_level_q(lvl), .microphone_bias_output_en_q(bias_en),
    .analog_input_one_cm_q(cm1), .analog_input_two_cm_q(cm2),
    .timer_defaults_valid_q(valid));
  always #50 clock = ~clock;
  // 1 MHz step every 10 cycles, oscillator step every 2 cycles
  always @(negedge clock) begin
    ph = ph + 1;
    mhz_tick = (ph % 10 == 0);
    osc_tick = ph[0];
  end
  always @(posedge clock) begin
    ncyc = ncyc + 1;
    if (ncyc == 30000) begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end
  // ==========
  // checking
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wrm(input int i, input logic [7:0] x);
    host.wr(offs[i], x);
    // a reserved drive code keeps the old drive field, the rest of the byte lands
    if (i == 0 && x[4:3] == 2'h2) mdl[0] = {x[7:5], mdl[0][4:3], x[2], 2'h0};
    else mdl[i] = x & ((i == 0) ? 8'hfc : (i == 1) ? 8'h8b : 8'hc0);
  endtask : wrm
  task automatic verify();
    for (int i = 0; i < 3; i++) begin
      host.rd(offs[i], d, v);
      chk({d, 7'h00, v}, {mdl[i], 8'h01});
    end
    chk({drive, aux, pd, lvl, cm1, cm2},
      {mdl[0][4:2], mdl[1][7], mdl[1][1:0], mdl[2][7:6]});
  endtask : verify
  task automatic bias(input logic ovr, input logic det, input logic pres, input logic e);
    wrm(1, {4'h0, ovr, 3'h1});
    headset_detect_en = det;
    headset_present_pin = pres;
    repeat (5) @(negedge clock);
    chk(bias_en, e);
  endtask : bias
  task automatic dbn(input logic [2:0] c, input logic s, input int e);
    d = mdl[0];
    d[7:5] = c;
    wrm(0, d);
    src_mclk = s;
    // a tick still in flight from the old code would shorten the measured gap
    @(negedge clock);
    for (k = 0; k < 2000 && !dbnc_tick_q; k++) @(negedge clock);
    @(negedge clock);
    for (k = 1; k < 2000 && !dbnc_tick_q; k++) @(negedge clock);
    chk(k, (c == 3'h0) ? 2000 : e);
  endtask : dbn
  task automatic report_and_stop();
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    soft_reset = 1'b0;
    src_mclk = 1'b1;
    headset_detect_en = 1'b0;
    headset_present_pin = 1'b0;
    mhz_tick = 1'b0;
    osc_tick = 1'b0;
    d = 8'($urandom(32'h7aac));
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    for (k = 0; k < 2000 && !valid; k++) @(negedge clock);
    chk(k, 1000);
    verify();
    for (int j = 0; j < 16; j++) begin
      d = 8'($urandom);
      d[4:3] = j[1:0];
      d[1:0] = j[1:0];
      wrm(j % 3, d);
      wrm(1, d);
      if (j % 4 == 3) verify();
    end
    foreach (rsv[i]) begin
      host.rd(rsv[i], d, v);
      chk(d, 0);
    end
    bias(0, 1, 0, 0);
    bias(0, 1, 1, 1);
    bias(1, 1, 0, 1);
    bias(0, 0, 0, 1);
    dbn(3'h0, 1, 0);
    dbn(3'h1, 1, 10);
    dbn(3'h3, 1, 40);
    dbn(3'h7, 1, 640);
    dbn(3'h2, 0, 32);
    wrm(2, 8'hc0);
    @(negedge clock);
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    chk(valid, 0);
    mdl = '{8'h00, 8'h00, 8'h00};
    verify();
    report_and_stop();
  end
endmodule : obc_regs_bench
